// ---- flash_lock_reset_control.sv ----
// Overview of operation
// - reset loads lock register from security byte
// - special locked mode: erase-all and verify-key commands only
// - new security byte waits for reset
// - backdoor unlock needs permit field enabled
// - key match forces lock field unlocked
// - failed compare blocks verify until reset
// - unlock touches only the lock register
// - reset reloads lock from stored byte
// - unlock leaves write guard untouched
// - unlocked chip may rewrite configuration sector
// - reset sequence initialises config registers
// - done flag cleared during reset sequence
// - cpu access stalled during reset sequence
// - done flag set when sequence ends
// - reset aborts running command at once
// - aborted command never resumes after reset
// - verify with permit disabled: access fault
// - all-zero or all-one key faults
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "flash_lock_params.svh"

module flash_lock_reset_control (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [31:0] wb_adr_in,
    input  wire logic [31:0] wb_dat_in,
    input  wire logic [3:0]  wb_sel_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    output logic             irq_out,
    output logic             cpu_stall_out,
    output logic             chip_locked_out
);

    typedef struct packed {
        flash_lock_pkg::phase_t phase;
        logic [7:0]  cnt;
        logic        special;
        logic [7:0]  cmd;
        logic        done;
        logic        fault;
        logic        key_blocked;
        logic        aborted;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic [7:0]  lock;
        logic [63:0] key;
        logic [31:0] guard;
        logic [7:0]  bootopt;
        logic [7:0]  cfg_sec;
        logic [63:0] cfg_key;
        logic [31:0] cfg_guard;
        logic [7:0]  cfg_boot;
        logic [31:0] rdata;
        logic        ack;
        logic        irq;
        logic        stall;
        logic        locked;
    } state_t;

    state_t cur_ff;
    state_t nxt_ff;

    function automatic logic is_unlocked(input logic [7:0] b);
        is_unlocked = (b[`LOCK_SEC_LSB +: 2] == `SEC_UNLOCKED);
    endfunction

    function automatic logic bulk_cmd(input logic [7:0] c);
        bulk_cmd = (c == `CMD_ERASE_ALL) || (c == `CMD_VERIFY_KEY);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sel);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = sel[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    logic wr;
    logic rd;
    logic launch;
    logic allowed;
    logic [2:0] ev;
    assign wr = wb_cyc_in && wb_stb_in && !cur_ff.ack && wb_we_in;
    assign rd = wb_cyc_in && wb_stb_in && !cur_ff.ack && !wb_we_in;
    assign launch = wr && (wb_adr_in == `OFS_CTRL) && wb_sel_in[0]
        && wb_dat_in[`CTRL_LAUNCH];

    assign allowed = !cur_ff.special || is_unlocked(cur_ff.lock)
        || bulk_cmd(cur_ff.cmd);

    always_comb begin
        nxt_ff = cur_ff;
        ev = 3'b000;
        nxt_ff.ack = wb_cyc_in && wb_stb_in && !cur_ff.ack;
        case (cur_ff.phase)
            flash_lock_pkg::ST_RESET_SEQ: begin
                nxt_ff.done = 1'b0;
                nxt_ff.stall = 1'b1;
                nxt_ff.lock = cur_ff.cfg_sec;
                nxt_ff.key = cur_ff.cfg_key;
                nxt_ff.guard = cur_ff.cfg_guard;
                nxt_ff.bootopt = cur_ff.cfg_boot;
                nxt_ff.cnt = cur_ff.cnt + 8'h01;
                if (cur_ff.cnt == 8'(`RST_SEQ_CYC - 1)) begin
                    nxt_ff.phase = flash_lock_pkg::ST_IDLE;
                    nxt_ff.done = 1'b1;
                    nxt_ff.stall = 1'b0;
                    nxt_ff.cnt = 8'h00;
                end
            end
            flash_lock_pkg::ST_IDLE: begin
                if (launch && cur_ff.done) begin
                    nxt_ff.cmd = wb_dat_in[`CTRL_CMD_LSB +: 8];
                    nxt_ff.done = 1'b0;
                    nxt_ff.fault = 1'b0;
                    nxt_ff.cnt = 8'h00;
                    nxt_ff.phase = flash_lock_pkg::ST_BUSY;
                end
            end
            flash_lock_pkg::ST_BUSY: begin
                nxt_ff.cnt = cur_ff.cnt + 8'h01;
                if (cur_ff.cnt == 8'(`CMD_RUN_CYC - 1)) begin
                    nxt_ff.phase = flash_lock_pkg::ST_IDLE;
                    nxt_ff.done = 1'b1;
                    ev[`EV_DONE] = 1'b1;
                    if (!allowed) begin
                        nxt_ff.fault = 1'b1;
                    end else if (cur_ff.cmd == `CMD_VERIFY_KEY) begin
                        if (cur_ff.lock[`LOCK_BACKDOOR_PERMIT_LSB +: 2]
                                != `BACKDOOR_PERMIT_ENABLED) begin
                            nxt_ff.fault = 1'b1;
                        end else if (cur_ff.key_blocked) begin
                            nxt_ff.fault = 1'b1;
                        end else if (cur_ff.key == 64'h0000_0000_0000_0000
                                || cur_ff.key == 64'hFFFF_FFFF_FFFF_FFFF) begin
                            nxt_ff.fault = 1'b1;
                        end else if (cur_ff.key == cur_ff.cfg_key) begin
                            nxt_ff.lock[`LOCK_SEC_LSB +: 2] = `SEC_UNLOCKED;
                            ev[`EV_UNLOCK] = 1'b1;
                        end else begin
                            nxt_ff.fault = 1'b1;
                            nxt_ff.key_blocked = 1'b1;
                        end
                    end else if (cur_ff.cmd == `CMD_ERASE_ALL) begin
                        nxt_ff.cfg_sec = 8'hFF;
                        nxt_ff.cfg_key = 64'hFFFF_FFFF_FFFF_FFFF;
                        nxt_ff.lock[`LOCK_SEC_LSB +: 2] = `SEC_UNLOCKED;
                    // config sector writable, no live effect
                    end else if (cur_ff.cmd == `CMD_ERASE_SECT) begin
                        nxt_ff.cfg_sec = 8'hFF;
                        nxt_ff.cfg_key = 64'hFFFF_FFFF_FFFF_FFFF;
                    end
                    ev[`EV_FAULT] = nxt_ff.fault;
                end
            end
            default: nxt_ff.phase = flash_lock_pkg::ST_IDLE;
        endcase

        if (wr && cur_ff.phase != flash_lock_pkg::ST_BUSY) begin
            case (wb_adr_in)
                `OFS_CTRL: begin
                    if (wb_sel_in[0]) begin
                        nxt_ff.special = wb_dat_in[`CTRL_SPECIAL];
                    end
                end
                `OFS_IRQ_MASK: nxt_ff.irq_mask =
                    3'(merge({29'h0, cur_ff.irq_mask}, wb_dat_in,
                             wb_sel_in));
                `OFS_KEY_LO: nxt_ff.key[31:0] =
                    merge(cur_ff.key[31:0], wb_dat_in, wb_sel_in);
                `OFS_KEY_HI: nxt_ff.key[63:32] =
                    merge(cur_ff.key[63:32], wb_dat_in, wb_sel_in);
                `OFS_CFG_SEC: nxt_ff.cfg_sec = 8'(merge({24'h0,
                    cur_ff.cfg_sec}, wb_dat_in, wb_sel_in));
                `OFS_CFG_KEY_LO: nxt_ff.cfg_key[31:0] =
                    merge(cur_ff.cfg_key[31:0], wb_dat_in, wb_sel_in);
                `OFS_CFG_KEY_HI: nxt_ff.cfg_key[63:32] =
                    merge(cur_ff.cfg_key[63:32], wb_dat_in, wb_sel_in);
                `OFS_CFG_GUARD: nxt_ff.cfg_guard =
                    merge(cur_ff.cfg_guard, wb_dat_in, wb_sel_in);
                `OFS_CFG_BOOT: nxt_ff.cfg_boot = 8'(merge({24'h0,
                    cur_ff.cfg_boot}, wb_dat_in, wb_sel_in));
                default: ;
            endcase
        end

        nxt_ff.rdata = 32'h0000_0000;
        if (rd) begin
            case (wb_adr_in)
                `OFS_CTRL: nxt_ff.rdata = {16'h0, cur_ff.cmd, 6'h0,
                    cur_ff.special, 1'b0};
                `OFS_STATUS: nxt_ff.rdata = {28'h0, cur_ff.aborted,
                    cur_ff.key_blocked, cur_ff.fault, cur_ff.done};
                `OFS_IRQ_STAT: nxt_ff.rdata = {29'h0, cur_ff.irq_stat};
                `OFS_IRQ_MASK: nxt_ff.rdata = {29'h0, cur_ff.irq_mask};
                `OFS_LOCK: nxt_ff.rdata = {24'h0, cur_ff.lock};
                `OFS_GUARD: nxt_ff.rdata = cur_ff.guard;
                `OFS_BOOTOPT: nxt_ff.rdata = {24'h0, cur_ff.bootopt};
                `OFS_CFG_SEC: nxt_ff.rdata = {24'h0, cur_ff.cfg_sec};
                `OFS_CFG_KEY_LO: nxt_ff.rdata = cur_ff.cfg_key[31:0];
                `OFS_CFG_GUARD: nxt_ff.rdata = cur_ff.cfg_guard;
                `OFS_CFG_BOOT: nxt_ff.rdata = {24'h0, cur_ff.cfg_boot};
                default: nxt_ff.rdata = 32'h0000_0000;
            endcase
        end

        // read clears, a new event in the same cycle still wins
        if (rd && wb_adr_in == `OFS_IRQ_STAT) begin
            nxt_ff.irq_stat = ev;
        end else begin
            nxt_ff.irq_stat = cur_ff.irq_stat | ev;
        end
        nxt_ff.irq = |(nxt_ff.irq_stat & cur_ff.irq_mask);
        nxt_ff.locked = !is_unlocked(nxt_ff.lock);
    end

    // stored field survives reset like flash cells do
    logic cfg_init_ff = 1'b0;
    always_ff @(posedge clk_in) begin
        if (!cfg_init_ff && !sys_rst_in) begin
            cfg_init_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            // first reset only: blank cells would poison the lock
            if (!cfg_init_ff) begin
                cur_ff.cfg_sec <= `CFG_SEC_RST;
                cur_ff.cfg_key <= `CFG_KEY_RST;
                cur_ff.cfg_guard <= `CFG_GUARD_RST;
                cur_ff.cfg_boot <= `CFG_BOOT_RST;
            end
            cur_ff.phase <= flash_lock_pkg::ST_RESET_SEQ;
            cur_ff.aborted <= (cur_ff.phase == flash_lock_pkg::ST_BUSY)
                || cur_ff.aborted;
            cur_ff.cnt <= 8'h00;
            cur_ff.special <= 1'b0;
            cur_ff.cmd <= 8'h00;
            cur_ff.done <= 1'b0;
            cur_ff.fault <= 1'b0;
            cur_ff.key_blocked <= 1'b0;
            cur_ff.irq_stat <= 3'b000;
            cur_ff.irq_mask <= 3'b000;
            cur_ff.lock <= 8'hFF;
            cur_ff.key <= 64'h0000_0000_0000_0000;
            cur_ff.guard <= 32'h0000_0000;
            cur_ff.bootopt <= 8'h00;
            cur_ff.rdata <= 32'h0000_0000;
            cur_ff.ack <= 1'b0;
            cur_ff.irq <= 1'b0;
            cur_ff.stall <= 1'b1;
            cur_ff.locked <= 1'b1;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign wb_dat_out = cur_ff.rdata;
    assign wb_ack_out = cur_ff.ack;
    assign irq_out = cur_ff.irq;
    assign cpu_stall_out = cur_ff.stall;
    assign chip_locked_out = cur_ff.locked;

    chk_done_in_seq: assert property (@(posedge clk_in) disable iff
        (sys_rst_in) cur_ff.phase == flash_lock_pkg::ST_RESET_SEQ
        |-> !cur_ff.done) else $error("done set during reset sequence");

    chk_stall_seq: assert property (@(posedge clk_in) disable iff
        (sys_rst_in) $fell(cur_ff.stall) |-> cur_ff.done
        && cur_ff.phase == flash_lock_pkg::ST_IDLE)
        else $error("stall released without done");

    chk_done_at_end: assert property (@(posedge clk_in) disable iff
        (sys_rst_in) $fell(sys_rst_in) |-> ##8 cur_ff.done)
        else $error("done not set after sequence");

    chk_lock_load: assert property (@(posedge clk_in) disable iff
        (sys_rst_in) $fell(sys_rst_in) |-> ##8 cur_ff.lock
        == $past(cur_ff.cfg_sec, 1)) else $error("lock not reloaded");

    chk_lock_out: assert property (@(posedge clk_in) disable iff
        (sys_rst_in) chip_locked_out == !is_unlocked(cur_ff.lock))
        else $error("lock output mismatch");

    chk_key_block: assert property (@(posedge clk_in) disable iff
        (sys_rst_in) cur_ff.key_blocked |=> cur_ff.key_blocked)
        else $error("key block cleared without reset");

    chk_guard_keep: assert property (@(posedge clk_in) disable iff
        (sys_rst_in) cur_ff.phase != flash_lock_pkg::ST_RESET_SEQ
        |=> $stable(cur_ff.guard)) else $error("guard changed");

    chk_trivial_key: assert property (@(posedge clk_in) disable iff
        (sys_rst_in) (cur_ff.phase == flash_lock_pkg::ST_BUSY
        && cur_ff.cmd == `CMD_VERIFY_KEY && cur_ff.key == 64'h0
        && !is_unlocked(cur_ff.lock) && $past(!is_unlocked(cur_ff.lock)))
        |=> cur_ff.done |-> cur_ff.fault)
        else $error("zero key accepted");

endmodule // flash_lock_reset_control
`default_nettype wire

// ---- flash_lock_params.svh ----
`ifndef FLASH_LOCK_PARAMS_SVH
`define FLASH_LOCK_PARAMS_SVH

// register byte offsets
`define OFS_CTRL        32'h0000_0000
`define OFS_STATUS      32'h0000_0004
`define OFS_IRQ_STAT    32'h0000_0008
`define OFS_IRQ_MASK    32'h0000_000C
`define OFS_LOCK        32'h0000_0010
`define OFS_KEY_LO      32'h0000_0014
`define OFS_KEY_HI      32'h0000_0018
`define OFS_GUARD       32'h0000_001C
`define OFS_BOOTOPT     32'h0000_0020
`define OFS_CFG_SEC     32'h0000_0024
`define OFS_CFG_KEY_LO  32'h0000_0028
`define OFS_CFG_KEY_HI  32'h0000_002C
`define OFS_CFG_GUARD   32'h0000_0030
`define OFS_CFG_BOOT    32'h0000_0034

// control register fields
`define CTRL_LAUNCH     0
`define CTRL_SPECIAL    1
`define CTRL_CMD_LSB    8
// status register fields
`define ST_DONE         0
`define ST_FAULT        1
`define ST_KEY_BLOCKED  2
`define ST_ABORTED      3
// event bits in the interrupt status
`define EV_DONE         0
`define EV_FAULT        1
`define EV_UNLOCK       2

// lock byte fields
`define LOCK_SEC_LSB    0
`define LOCK_BACKDOOR_PERMIT_LSB  6
`define SEC_UNLOCKED    2'b10
`define BACKDOOR_PERMIT_ENABLED   2'b10

// command codes
`define CMD_ERASE_ALL   8'h44
`define CMD_VERIFY_KEY  8'h45
`define CMD_ERASE_SECT  8'h09
`define CMD_PROGRAM     8'h07

// reset values of the stored configuration field
`define CFG_SEC_RST     8'hFE
`define CFG_KEY_RST     64'h0123_4567_89AB_CDEF
`define CFG_GUARD_RST   32'hFFFF_FFFF
`define CFG_BOOT_RST    8'hFF

// reset sequence and command execution timing
`define RST_SEQ_NS      80
`define CMD_RUN_NS      100
`define CLK_NS          10
`define RST_SEQ_CYC     (`RST_SEQ_NS / `CLK_NS)
`define CMD_RUN_CYC     (`CMD_RUN_NS / `CLK_NS)

`endif

// ---- flash_lock_pkg.sv ----
package flash_lock_pkg;
    typedef enum logic [1:0] {
        ST_RESET_SEQ,
        ST_IDLE,
        ST_BUSY
    } phase_t;
endpackage

// ---- tb_flash_lock_reset_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "flash_lock_params.svh"

module tb_flash_lock_reset_control;
    localparam logic [63:0] KEY   = 64'h1122_3344_5566_7788;
    localparam logic [31:0] GUARD = 32'h00F0_0F0F;
    logic        clk        = 1'b0;
    logic        rst        = 1'b1;
    logic        cyc        = 1'b0;
    logic        stb        = 1'b0;
    logic        we         = 1'b0;
    logic [31:0] adr        = 32'h0000_0000;
    logic [31:0] wdat       = 32'h0000_0000;
    logic [3:0]  sel        = 4'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        irq;
    logic        stall;
    logic        locked;
    logic [31:0] rd;
    int          num_errors = 0;
    int          cmp_count  = 0;

    always #5 clk = ~clk;

    flash_lock_reset_control u_dut (
        .clk_in          (clk),
        .sys_rst_in      (rst),
        .wb_cyc_in       (cyc),
        .wb_stb_in       (stb),
        .wb_we_in        (we),
        .wb_adr_in       (adr),
        .wb_dat_in       (wdat),
        .wb_sel_in       (sel),
        .wb_dat_out      (rdat),
        .wb_ack_out      (ack),
        .irq_out         (irq),
        .cpu_stall_out   (stall),
        .chip_locked_out (locked)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // classic cycle: hold everything until ack is sampled high
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'hF;
        do @(posedge clk); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    // busy time is fixed at 10 cycles, so a fixed wait is safe
    task automatic cmd(input logic [7:0] c, input logic sp);
        bus(1'b1, `OFS_CTRL, {16'h0000, c, 6'h00, sp, 1'b1});
        repeat (14) @(posedge clk);
        bus(1'b0, `OFS_STATUS, 32'h0000_0000);
    endtask

    task automatic key(input logic [63:0] k);
        bus(1'b1, `OFS_KEY_LO, k[31:0]);
        bus(1'b1, `OFS_KEY_HI, k[63:32]);
    endtask

    // stored cells survive reset; the first reset loads their default values
    task automatic cfg(input logic [7:0] sec);
        bus(1'b1, `OFS_CFG_SEC, {24'h00_0000, sec});
        bus(1'b1, `OFS_CFG_KEY_LO, KEY[31:0]);
        bus(1'b1, `OFS_CFG_KEY_HI, KEY[63:32]);
        bus(1'b1, `OFS_CFG_GUARD, GUARD);
        bus(1'b1, `OFS_CFG_BOOT, 32'h0000_005A);
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({31'h0, stall}, 32'h0000_0001);
        bus(1'b0, `OFS_STATUS, 32'h0000_0000);
        check({31'h0, rd[`ST_DONE]}, 32'h0000_0000);
        repeat (10) @(posedge clk);
        check({31'h0, stall}, 32'h0000_0000);
        bus(1'b0, `OFS_STATUS, 32'h0000_0000);
        check({31'h0, rd[`ST_DONE]}, 32'h0000_0001);
    endtask

    task automatic print_verdict();
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        cfg(8'h80);
        do_reset();
        rd_chk(`OFS_LOCK, 32'h0000_0080);
        check({31'h0, locked}, 32'h0000_0001);
        rd_chk(`OFS_GUARD, GUARD);
        rd_chk(`OFS_BOOTOPT, 32'h0000_005A);
        cmd(`CMD_ERASE_SECT, 1'b1);
        check(rd & 32'h0000_0003, 32'h0000_0003);
        for (int i = 0; i < 2; i++) begin
            key(i == 0 ? 64'h0 : ~64'h0);
            cmd(`CMD_VERIFY_KEY, 1'b0);
            check({31'h0, rd[`ST_FAULT]}, 32'h0000_0001);
            check({31'h0, locked}, 32'h0000_0001);
        end
        $display("test reset load and gating done");
        do_reset();
        key(KEY ^ 64'h1);
        cmd(`CMD_VERIFY_KEY, 1'b0);
        check({31'h0, rd[`ST_FAULT]}, 32'h0000_0001);
        key(KEY);
        cmd(`CMD_VERIFY_KEY, 1'b0);
        check(rd & 32'h0000_0006, 32'h0000_0006);
        check({31'h0, locked}, 32'h0000_0001);
        $display("test failed compare done");
        do_reset();
        bus(1'b1, `OFS_IRQ_MASK, 32'h0000_0007);
        bus(1'b0, `OFS_IRQ_STAT, 32'h0000_0000);
        key(KEY);
        cmd(`CMD_VERIFY_KEY, 1'b0);
        check(rd & 32'h0000_0003, 32'h0000_0001);
        rd_chk(`OFS_LOCK, 32'h0000_0082);
        check({31'h0, locked}, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0001);
        rd_chk(`OFS_GUARD, GUARD);
        rd_chk(`OFS_CFG_SEC, 32'h0000_0080);
        rd_chk(`OFS_CFG_KEY_LO, KEY[31:0]);
        rd_chk(`OFS_IRQ_STAT, 32'h0000_0005);
        bus(1'b1, `OFS_IRQ_MASK, 32'h0000_0001);
        cmd(`CMD_ERASE_SECT, 1'b1);
        check(rd & 32'h0000_0003, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0001);
        rd_chk(`OFS_IRQ_STAT, 32'h0000_0001);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0000_0000);
        $display("test backdoor unlock done");
        cfg(8'h80);
        do_reset();
        rd_chk(`OFS_LOCK, 32'h0000_0080);
        check({31'h0, locked}, 32'h0000_0001);
        bus(1'b1, `OFS_CFG_SEC, 32'h0000_0000);
        rd_chk(`OFS_LOCK, 32'h0000_0080);
        do_reset();
        rd_chk(`OFS_LOCK, 32'h0000_0000);
        key(KEY);
        cmd(`CMD_VERIFY_KEY, 1'b0);
        check({31'h0, rd[`ST_FAULT]}, 32'h0000_0001);
        check({31'h0, locked}, 32'h0000_0001);
        $display("test permit and reload done");
        // a reset lands while the verify is still busy
        bus(1'b1, `OFS_CFG_SEC, 32'h0000_0080);
        do_reset();
        key(KEY);
        bus(1'b1, `OFS_CTRL, {16'h0000, `CMD_VERIFY_KEY, 8'h01});
        repeat (3) @(posedge clk);
        do_reset();
        check({31'h0, rd[`ST_ABORTED]}, 32'h0000_0001);
        repeat (20) @(posedge clk);
        rd_chk(`OFS_LOCK, 32'h0000_0080);
        check({31'h0, locked}, 32'h0000_0001);
        $display("test abort done");
        print_verdict();
    end
endmodule // tb_flash_lock_reset_control

`default_nettype wire
